/* File: verilog/ebw_bus_config.sv */
// Bus width and idle-cycle configuration with access sequencer
// Assumes an APB master on pclk, ROM-enable and width strap pins from
// outside the clock domain, and an external bus engine that pulses
// ext_done once per external cycle on the same clock
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/1ps

// Overview of operation
// - Pair 2/6 runs 8-bit for size bit 0, 16-bit for 1.
// - Pair 2/6 longword select 1 forces 32-bit, size bit ignored.
// - Pair 1/5 runs 8-bit for size bit 0, 16-bit for 1.
// - Pair 1/5 longword select 1 forces 32-bit, size bit ignored.
// - ROM enabled, pair 0/4 runs 8-bit or 16-bit from size bit.
// - ROM disabled, pair 0/4 width comes from the mode pin.
// - ROM enabled with longword select 1, pair 0/4 is 32-bit.
// - Size bits reset to 1 and are read/write; default 16-bit.
// - After reading 3/7, idle before write there or other-space access.
// - Pair 3/7 idle field 00..11 gives zero to three idle cycles.
// - After reading 2/6, idle before write there or other-space access.
// - Pair 2/6 idle field 00..11 gives zero to three idle cycles.
// - Both idle fields reset to ones and are read/write.
// - Longword selects reset to 0; 0 defers to the size bit.
module ebw_bus_config (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        pclk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rom_enable_pin,
    input  wire logic [1:0]  mode_width_pin,
    input  wire logic        req_valid,
    input  wire logic [2:0]  req_cs,
    input  wire logic        req_write,
    input  wire logic [1:0]  req_size,
    input  wire logic [31:0] req_addr,
    output logic             req_ready,
    output logic             req_done,
    output logic             ext_start,
    output logic      [2:0]  ext_cs,
    output logic             ext_write,
    output logic      [1:0]  ext_width,
    output logic      [31:0] ext_addr,
    output logic             ext_last,
    input  wire logic        ext_done
);

    typedef struct packed {
        logic                  rom_sync1;
        logic                  rom_sync2;
        logic [1:0]            mode_sync1;
        logic [1:0]            mode_sync2;
        logic [15:0]           bus_width_control;
        logic [15:0]           idle_cycle_control;
        logic [31:0]           prdata;
        logic                  pready;
        logic                  pslverr;
        ebw_pkg::ebw_state_type state;
        logic                  req_ready;
        logic                  req_done;
        logic                  ext_start;
        logic [2:0]            ext_cs;
        logic                  ext_write;
        logic [1:0]            ext_width;
        logic [31:0]           ext_addr;
        logic                  ext_last;
        logic [2:0]            parts_left;
        logic                  last_read;
        logic [1:0]            last_pair;
    } ebw_core_state_type;

    ebw_core_state_type r;
    ebw_core_state_type next_r;

    logic       gap_busy;
    logic       gap_load;
    logic [1:0] gap_count;

    // Width of one chip-select pair from the control bits and straps
    function automatic ebw_pkg::ebw_width_type pair_width(
        input logic [1:0]  pair,
        input logic [15:0] bwc,
        input logic        rom_en,
        input logic [1:0]  mode_w
    );
        logic lg;
        logic sz;
        lg = bwc[ebw_pkg::LONGWORD_SEL_LSB + pair];
        sz = bwc[ebw_pkg::SIZE_BIT_LSB + pair];
        if (pair == 2'h0 && !rom_en) begin
            // Reserved strap code 11 falls back to word width
            if (mode_w == 2'b11) begin
                pair_width = ebw_pkg::EBW_W16;
            end else begin
                pair_width = ebw_pkg::ebw_width_type'(mode_w);
            end
        end else if (lg) begin
            pair_width = ebw_pkg::EBW_W32;
        end else if (sz) begin
            pair_width = ebw_pkg::EBW_W16;
        end else begin
            pair_width = ebw_pkg::EBW_W8;
        end
    endfunction

    // Byte-lane merge of an APB write into a 16-bit register
    function automatic logic [15:0] merge_write(
        input logic [15:0] old,
        input logic [31:0] wdata,
        input logic [3:0]  strb,
        input logic [15:0] wmask,
        input logic [15:0] fixed1
    );
        logic [15:0] lanes;
        lanes = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
        merge_write = (old & ~lanes) | (wdata[15:0] & lanes) | fixed1;
    endfunction

    // Idle cycles owed after a read of the given pair
    function automatic logic [1:0] idle_for_pair(
        input logic [1:0]  pair,
        input logic [15:0] icc
    );
        case (pair)
            ebw_pkg::PAIR_37:
                idle_for_pair = icc[ebw_pkg::IDLE37_LSB +: 2];
            ebw_pkg::PAIR_26:
                idle_for_pair = icc[ebw_pkg::IDLE26_LSB +: 2];
            default:
                idle_for_pair = ebw_pkg::IDLE_NONE;
        endcase
    endfunction

    // Decoded widths of all four pairs, shown in the status register
    logic [7:0] width_map;

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_width
            assign width_map[2*gi +: 2] = pair_width(2'(gi),
                r.bus_width_control, r.rom_sync2, r.mode_sync2);
        end
    endgenerate

    ebw_idle_gap #(
        .CNT_W (2)
    ) u_gap (
        .pclk    (pclk),
        .presetn (presetn),
        .pclk_en (pclk_en),
        .load    (gap_load),
        .count   (gap_count),
        .busy    (gap_busy)
    );

    always_comb begin
        logic                  apb_done;
        logic                  take;
        logic [1:0]            req_pair;
        logic [1:0]            owed;
        logic                  need_gap;
        ebw_pkg::ebw_width_type w;
        logic [2:0]            parts;
        logic [31:0]           step;

        next_r    = r;
        apb_done  = psel & penable & r.pready;
        take      = req_valid & r.req_ready;
        req_pair  = req_cs[1:0];
        owed      = idle_for_pair(r.last_pair, r.idle_cycle_control);
        // Same-pair reads need no gap; writes or other pairs do
        need_gap  = r.last_read & (owed != 2'h0)
                    & (req_write | (req_pair != r.last_pair));
        w         = ebw_pkg::ebw_width_type'(r.ext_width);
        step      = 32'h0000_0001 << r.ext_width;
        parts     = 3'h1;
        gap_load  = 1'b0;
        // GAP state is itself the first idle cycle, so load one less
        gap_count = owed - 2'h1;

        // Pin straps pass two flops before use
        next_r.rom_sync1  = rom_enable_pin;
        next_r.rom_sync2  = r.rom_sync1;
        next_r.mode_sync1 = mode_width_pin;
        next_r.mode_sync2 = r.mode_sync1;

        // APB: answer one cycle into the access phase
        next_r.pready  = psel & penable & ~r.pready;
        next_r.pslverr = 1'b0;
        if (psel & penable & ~r.pready) begin
            next_r.prdata = 32'h0000_0000;
            case (paddr)
                ebw_pkg::ADDR_BUS_WIDTH_CONTROL:
                    next_r.prdata = {16'h0000, r.bus_width_control};
                ebw_pkg::ADDR_IDLE_CYCLE_CONTROL:
                    next_r.prdata = {16'h0000, r.idle_cycle_control};
                ebw_pkg::ADDR_WIDTH_STATUS: begin
                    next_r.prdata[7:0] = width_map;
                    next_r.prdata[ebw_pkg::STATUS_BUSY_BIT] =
                        (r.state != ebw_pkg::EBW_ST_IDLE);
                    next_r.prdata[ebw_pkg::STATUS_ROM_BIT] = r.rom_sync2;
                    next_r.pslverr = pwrite;
                end
                default:
                    next_r.pslverr = 1'b1;
            endcase
        end
        // Writes land only at the edge that completes the transfer
        if (apb_done && pwrite) begin
            if (paddr == ebw_pkg::ADDR_BUS_WIDTH_CONTROL) begin
                // Not locked: changing widths mid-run is software's risk
                next_r.bus_width_control = merge_write(r.bus_width_control,
                    pwdata, pstrb, ebw_pkg::BWC_WMASK,
                    ebw_pkg::BWC_FIXED1);
            end
            if (paddr == ebw_pkg::ADDR_IDLE_CYCLE_CONTROL) begin
                next_r.idle_cycle_control = merge_write(
                    r.idle_cycle_control, pwdata, pstrb,
                    ebw_pkg::ICC_WMASK, ebw_pkg::ICC_FIXED1);
            end
        end

        next_r.ext_start = 1'b0;
        next_r.req_done  = 1'b0;

        case (r.state)
            ebw_pkg::EBW_ST_IDLE: begin
                if (take) begin
                    w = pair_width(req_pair, r.bus_width_control,
                        r.rom_sync2, r.mode_sync2);
                    if (req_size > 2'(w)) begin
                        parts = 3'h1 << (req_size - 2'(w));
                    end
                    next_r.req_ready  = 1'b0;
                    next_r.ext_cs     = req_cs;
                    next_r.ext_write  = req_write;
                    next_r.ext_width  = 2'(w);
                    next_r.ext_addr   = req_addr;
                    next_r.parts_left = parts;
                    next_r.ext_last   = (parts == 3'h1);
                    if (need_gap) begin
                        gap_load     = 1'b1;
                        next_r.state = ebw_pkg::EBW_ST_GAP;
                    end else begin
                        next_r.ext_start = 1'b1;
                        next_r.state     = ebw_pkg::EBW_ST_CYCLE;
                    end
                end
            end
            ebw_pkg::EBW_ST_GAP: begin
                // Bus stays idle until the owed cycles have run out
                if (!gap_busy) begin
                    next_r.ext_start = 1'b1;
                    next_r.state     = ebw_pkg::EBW_ST_CYCLE;
                end
            end
            ebw_pkg::EBW_ST_CYCLE: begin
                if (ext_done && !r.ext_start) begin
                    if (r.parts_left == 3'h1) begin
                        next_r.req_done  = 1'b1;
                        next_r.req_ready = 1'b1;
                        next_r.last_read = ~r.ext_write;
                        next_r.last_pair = r.ext_cs[1:0];
                        next_r.state     = ebw_pkg::EBW_ST_IDLE;
                    end else begin
                        next_r.parts_left = r.parts_left - 3'h1;
                        next_r.ext_addr   = r.ext_addr + step;
                        next_r.ext_last   = (r.parts_left == 3'h2);
                        next_r.ext_start  = 1'b1;
                    end
                end
            end
            default: begin
                next_r.state     = ebw_pkg::EBW_ST_IDLE;
                next_r.req_ready = 1'b1;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r                    <= '0;
            r.bus_width_control  <= ebw_pkg::BWC_RESET;
            r.idle_cycle_control <= ebw_pkg::ICC_RESET;
            r.state              <= ebw_pkg::EBW_ST_IDLE;
            r.req_ready          <= 1'b1;
            r.ext_last           <= 1'b1;
            r.parts_left         <= 3'h1;
        end else if (pclk_en) begin
            r <= next_r;
        end
    end

    assign prdata    = r.prdata;
    assign pready    = r.pready;
    assign pslverr   = r.pslverr;
    assign req_ready = r.req_ready;
    assign req_done  = r.req_done;
    assign ext_start = r.ext_start;
    assign ext_cs    = r.ext_cs;
    assign ext_write = r.ext_write;
    assign ext_width = r.ext_width;
    assign ext_addr  = r.ext_addr;
    assign ext_last  = r.ext_last;

endmodule

/* File: verilog/ebw_pkg.sv */
// Package: constants, field layout and types of the bus width / idle config
// Assumes one 250 MHz APB clock; all files use ebw_pkg:: names
package ebw_pkg;

    localparam int unsigned PADDR_W = 12;

    // Register byte offsets
    localparam logic [11:0] ADDR_BUS_WIDTH_CONTROL  = 12'h000;
    localparam logic [11:0] ADDR_IDLE_CYCLE_CONTROL = 12'h004;
    localparam logic [11:0] ADDR_WIDTH_STATUS       = 12'h008;

    // Values after reset, writable bits, bits that always read one
    localparam logic [15:0] BWC_RESET  = 16'h600F;
    localparam logic [15:0] BWC_WMASK  = 16'h20FF;
    localparam logic [15:0] BWC_FIXED1 = 16'h4000;
    localparam logic [15:0] ICC_RESET  = 16'hF000;
    localparam logic [15:0] ICC_WMASK  = 16'hF000;
    localparam logic [15:0] ICC_FIXED1 = 16'h0000;

    // Field positions
    localparam int unsigned SIZE_BIT_LSB     = 0;
    localparam int unsigned LONGWORD_SEL_LSB = 4;
    localparam int unsigned IDLE26_LSB       = 12;
    localparam int unsigned IDLE37_LSB       = 14;
    localparam int unsigned STATUS_BUSY_BIT  = 8;
    localparam int unsigned STATUS_ROM_BIT   = 9;

    // Chip-select pairs (low two bits of the space number)
    localparam logic [1:0] PAIR_26 = 2'h2;
    localparam logic [1:0] PAIR_37 = 2'h3;

    // Idle cycles left for pairs whose idle fields are not held here
    localparam logic [1:0] IDLE_NONE = 2'h0;

    typedef enum logic [1:0] {
        EBW_W8  = 2'b00,
        EBW_W16 = 2'b01,
        EBW_W32 = 2'b10
    } ebw_width_type;

    typedef enum logic [1:0] {
        EBW_ST_IDLE  = 2'b00,
        EBW_ST_GAP   = 2'b01,
        EBW_ST_CYCLE = 2'b11
    } ebw_state_type;

endpackage

/* File: verilog/ebw_idle_gap.sv */
// Idle-gap counter: holds busy for the loaded number of cycles
// Assumes load is a one-cycle pulse from the sequencer on the same clock
`timescale 1ns/1ps
module ebw_idle_gap #(
    parameter int unsigned CNT_W = 2
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic             pclk_en,
    input  wire logic             load,
    input  wire logic [CNT_W-1:0] count,
    output logic                  busy
);

    typedef struct packed {
        logic [CNT_W-1:0] remain;
    } ebw_gap_state_type;

    ebw_gap_state_type r;
    ebw_gap_state_type next_r;

    always_comb begin
        next_r = r;
        if (load) begin
            next_r.remain = count;
        end else if (r.remain != '0) begin
            next_r.remain = r.remain - 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else if (pclk_en) begin
            r <= next_r;
        end
    end

    assign busy = (r.remain != '0);

endmodule

/* File: dv/ebw_bus_config_chk.sv */
// Checker: APB answer, width choice and external cycle relations
// Assumes binding onto ebw_bus_config; pair 0/4 left out (strap sync)
`timescale 1ns/1ps
module ebw_bus_config_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        req_valid,
    input wire logic        req_ready,
    input wire logic        req_done,
    input wire logic        ext_start,
    input wire logic [2:0]  ext_cs,
    input wire logic [1:0]  ext_width,
    input wire logic [31:0] ext_addr,
    input wire logic        ext_last,
    input wire logic        ext_done
);
    logic [7:0]  sh_low;
    logic [31:0] next_addr;
    logic        more;
    logic        pair_hi;
    assign pair_hi = ext_start && ext_cs[1:0] != 2'h0;
    // Shadow of the width byte; written at the edge pready is sampled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_low    <= 8'h0F;
            next_addr <= 32'h0000_0000;
            more      <= 1'b0;
        end else begin
            if (psel && penable && pready && pwrite && paddr == 12'h000
                && pstrb[0])
                sh_low <= pwdata[7:0];
            if (ext_start) begin
                next_addr <= ext_addr + (32'h0000_0001 << ext_width);
                more      <= !ext_last;
            end
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ready; psel && penable && !pready |=> pready; endproperty
    a_ready: assert property (p_ready) else $error("pready late");
    property p_once; pready |=> !pready; endproperty
    a_once: assert property (p_once) else $error("pready held");
    property p_err; pready && (paddr > 12'h008 || paddr[1:0] != 2'h0
        || (pwrite && paddr == 12'h008)) |-> pslverr; endproperty
    a_err: assert property (p_err) else $error("missing pslverr");
    property p_w32; pair_hi && sh_low[{1'b1, ext_cs[1:0]}]
        |-> ext_width == ebw_pkg::EBW_W32; endproperty
    a_w32: assert property (p_w32) else $error("not 32 bit");
    property p_wsz; pair_hi && !sh_low[{1'b1, ext_cs[1:0]}] |-> ext_width ==
        (sh_low[{1'b0, ext_cs[1:0]}] ? ebw_pkg::EBW_W16 : ebw_pkg::EBW_W8);
    endproperty
    a_wsz: assert property (p_wsz) else $error("bad width");
    property p_step; ext_start && more |-> ext_addr == next_addr; endproperty
    a_step: assert property (p_step) else $error("bad part addr");
    property p_fin; req_done |-> $past(ext_done) && ext_last; endproperty
    a_fin: assert property (p_fin) else $error("early done");
    property p_hold; !ext_start && !req_ready && !$past(req_ready)
        |-> $stable(ext_addr) && $stable(ext_cs)
        && $stable(ext_width); endproperty
    a_hold: assert property (p_hold) else $error("ext fields moved");
    property p_take; req_valid && req_ready |=> !req_ready; endproperty
    a_take: assert property (p_take) else $error("ready after take");
    property p_rdy; req_done |-> req_ready ##1 !ext_start; endproperty
    a_rdy: assert property (p_rdy) else $error("not ready at done");
endmodule
bind ebw_bus_config ebw_bus_config_chk chk_u (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
    .pslverr(pslverr), .req_valid(req_valid), .req_ready(req_ready),
    .req_done(req_done), .ext_start(ext_start), .ext_cs(ext_cs),
    .ext_width(ext_width), .ext_addr(ext_addr), .ext_last(ext_last),
    .ext_done(ext_done));

/* File: dv/ebw_ext_mem.sv */
// Far-side memory model: ends each external cycle with ext_done
// Assumes ext_start is a one-cycle pulse; delay picks a slow answer
`timescale 1ns/1ps
module ebw_ext_mem (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       ext_start,
    input  wire logic [1:0] delay,
    output logic            ext_done
);
    int cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt      <= 0;
            ext_done <= 1'b0;
        end else begin
            ext_done <= (cnt == 1);
            if (ext_start)
                cnt <= int'(delay) + 1;
            else if (cnt != 0)
                cnt <= cnt - 1;
        end
    end
endmodule

/* File: dv/ext_bus_width_idle_config_tb.sv */
// Testbench: register, width and idle-gap runs against a queue-free model
// Assumes ebw_ext_mem on the far side and the bound checker
`timescale 1ns/1ps
module ext_bus_width_idle_config_tb;
    logic        pclk = 1'b0, presetn = 1'b0, rom_en = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, req_addr = 32'h0000_0000;
    logic [31:0] prdata, ext_addr;
    logic [1:0]  mode_w = 2'h0, delay = 2'h0, req_size = 2'h0, ext_width;
    logic        req_valid = 1'b0, req_write = 1'b0, req_ready, req_done;
    logic [2:0]  req_cs = 3'h0, ext_cs;
    logic        pready, pslverr, ext_start, ext_write, ext_last, ext_done;
    int          fails = 0, cmp_count = 0, cycles = 0, seed = 39;
    int          bwc = 'h600F, icc = 'hF000, last_rd = -1;
    ebw_bus_config dut_u (.pclk(pclk), .presetn(presetn), .pclk_en(1'b1),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rom_enable_pin(rom_en), .mode_width_pin(mode_w),
        .req_valid(req_valid), .req_cs(req_cs), .req_write(req_write),
        .req_size(req_size), .req_addr(req_addr), .req_ready(req_ready),
        .req_done(req_done), .ext_start(ext_start), .ext_cs(ext_cs),
        .ext_write(ext_write), .ext_width(ext_width), .ext_addr(ext_addr),
        .ext_last(ext_last), .ext_done(ext_done));
    ebw_ext_mem mem_u (.pclk(pclk), .presetn(presetn),
        .ext_start(ext_start), .delay(delay), .ext_done(ext_done));
    always #2 pclk = ~pclk;
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            give_verdict();
        end
    end
    // Reset pulse; the bwc, icc and last_rd shadows return to their reset values
    task automatic rst();
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        bwc = 'h600F;
        icc = 'hF000;
        last_rd = -1;
    endtask
    task automatic chk(input string what, input logic [63:0] exp, got);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic int wexp(int p);
        if (p == 0 && !rom_en)
            return mode_w == 2'h2 ? 2 : (mode_w == 2'h0 ? 0 : 1);
        if (bwc[4+p])
            return 2;
        return bwc[p];
    endfunction
    task automatic acc(input logic wr, input logic [11:0] a, input int d);
        logic [31:0] rd, ex;
        logic        err;
        ex = a == 12'h000 ? bwc : (a == 12'h004 ? icc : 0);
        if (a == 12'h008)
            ex = wexp(0) | wexp(1) << 2 | wexp(2) << 4 | wexp(3) << 6
                | rom_en << 9;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        chk("pslverr", a > 12'h008 || (wr && a == 12'h008), err);
        if (!wr)
            chk("prdata", ex, rd);
        else if (a == 12'h000)
            bwc = d & 'h20FF | 'h4000;
        else if (a == 12'h004)
            icc = d & 'hF000;
    endtask
    task automatic xfer(input int cs, input logic wr, input int sz);
        int          p, w, parts, owed, lat, n;
        logic [31:0] a;
        p = cs % 4;
        w = wexp(p);
        parts = sz > w ? 1 << (sz - w) : 1;
        owed = 0;
        if (last_rd >= 2 && (wr || p != last_rd))
            owed = last_rd == 2 ? icc[13:12] : icc[15:14];
        last_rd = wr ? -1 : p;
        a = $random(seed) & 32'hFFFF_FFFC;
        @(posedge pclk);
        req_valid <= 1'b1;
        req_cs <= cs[2:0];
        req_write <= wr;
        req_size <= sz[1:0];
        req_addr <= a;
        do @(posedge pclk); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        lat = 0;
        n = 0;
        while (req_done !== 1'b1) begin
            @(posedge pclk);
            lat++;
            if (ext_start === 1'b1) begin
                if (n == 0)
                    chk("latency", 1 + owed, lat);
                chk("ext", {cs[2:0], wr, w[1:0], a + n * (1 << w),
                    n == parts - 1}, {ext_cs, ext_write, ext_width,
                    ext_addr, ext_last});
                n++;
            end
        end
        chk("parts", parts, n);
    endtask
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        acc(0, 12'h000, 0);
        acc(0, 12'h004, 0);
        acc(0, 12'h008, 0);
        acc(0, 12'h00C, 0);
        acc(1, 12'h008, 0);
        acc(1, 12'h100, 0);
        for (int k = 0; k < 4; k++) begin
            acc(1, 12'h004, k << 12 | (3 - k) << 14);
            xfer(2, 0, 1);
            xfer(6, 1, 2);
            xfer(3, 0, 0);
            xfer(7, 0, 2);
            xfer(3, 1, 1);
            xfer(2, 0, 0);
            xfer(6, 0, 1);
            xfer(5, 0, 2);
            xfer(7, 0, 0);
            xfer(0, 1, 0);
        end
        for (int i = 0; i < 60; i++) begin
            delay <= $random(seed);
            if (i % 4 == 0) begin
                rst();
                acc(1, 12'h000, $random(seed));
            end
            if (i % 8 == 3)
                acc(1, 12'h004, $random(seed));
            if (i % 8 == 5) begin
                rom_en <= $random(seed);
                mode_w <= $random(seed);
                repeat (4) @(posedge pclk);
                acc(0, 12'h008, 0);
            end
            xfer({$random(seed)} % 8, $random(seed), {$random(seed)} % 3);
        end
        rst();
        acc(0, 12'h000, 0);
        acc(0, 12'h004, 0);
        give_verdict();
    end
endmodule
